// File: design/timekeeper_defines.vh
/*
 Constants of the serial timekeeper: command byte fields, register indices,
 reset values, link phases and the bus register map.
 Assumes inclusion by bare name from the design files.
*/
`ifndef TIMEKEEPER_DEFINES_VH
`define TIMEKEEPER_DEFINES_VH

// Command byte fields
`define CMD_WR_EN_BIT     7
`define CMD_RAM_BIT       6
`define CMD_ADDR_HI       5
`define CMD_ADDR_LO       1
`define CMD_READ_BIT      0
`define BURST_ADDR        5'h1f

// Byte and burst sizes
`define BIT_LAST          3'h7
`define CLK_REGS          8
`define CLK_LAST          5'h07
`define TRICKLE_ADDR      5'h08
`define RAM_BYTES         31
`define RAM_LAST          5'h1e

// Clock register indices and fields
`define SEC_IDX           3'h0
`define MIN_IDX           3'h1
`define CTRL_IDX          3'h7
`define HALT_BIT          7
`define WP_BIT            7
`define CTRL_MASK         8'h80
`define CTRL_RESET        8'h00
`define CLK_RESET         8'h00
`define BCD_59            7'h59
`define BCD_UNIT_9        4'h9

// Trickle register fields
`define TRICKLE_RESET     8'h00
`define TCS_HI            7
`define TCS_LO            4
`define TCS_ENABLE        4'ha
`define DS_HI             3
`define DS_LO             2
`define RS_HI             1
`define RS_LO             0
`define DS_ONE            2'b01
`define DS_TWO            2'b10
`define RS_NONE           2'b00
`define RS_R1             2'b01
`define RS_R2             2'b10
`define RS_R3             2'b11

// Link phases, one-hot
`define ST_CMD            3'b001
`define ST_DATA           3'b010
`define ST_DONE           3'b100

// Bus register map
`define REG_LINK_CTRL     4'h0
`define REG_LINK_STATUS   4'h4
`define REG_CHARGE        4'h8
`define REG_TIME          4'hc
`define LINK_CTRL_RESET   1'b1
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

// File: design/bit_sync.v
/*
 Two flip-flop synchroniser for a group of independent level inputs.
 Assumes each bit may change asynchronously to clk_i; no bit is a bus word.
*/
`timescale 1ns/1ps
module bit_sync #(
   parameter WIDTH = 1
) (
   input  wire             clk_i,
   input  wire             arst_n_i,
   input  wire             en_i,
   input  wire [WIDTH-1:0] d_i,
   output wire [WIDTH-1:0] q_o
);
   reg [WIDTH-1:0] meta;
   reg [WIDTH-1:0] stable;

   always @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta   <= {WIDTH{1'b0}};
         stable <= {WIDTH{1'b0}};
      end else if (en_i) begin
         meta   <= d_i;
         stable <= meta;
      end
   end

   assign q_o = stable;
endmodule

// File: design/timekeeper_burst_access.v
/*
 Serial timekeeper core: three-wire link slave with single and burst access to
 eight clock registers and 31 RAM bytes, single access to a trickle register, charger decode,
 a seconds counter and an AXI4-Lite status/control slave.
 Assumes link pins and the oscillator tick are asynchronous to mclk_i and
 the link clock is far slower than mclk_i.
*/
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "timekeeper_defines.vh"
module timekeeper_burst_access (
   input  wire        mclk_i,
   input  wire        arst_n_i,
   input  wire        clk_en_i,
   input  wire        xfer_en_i,
   input  wire        sclk_i,
   input  wire        sdio_i,
   output reg         sdio_o,
   output reg         sdio_oe_o,
   input  wire        osc_tick_i,
   output wire        charge_on_o,
   output wire [1:0]  charge_diode_o,
   output wire [2:0]  charge_resistor_o,
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready
);
   wire [3:0] pin_s;
   reg        sclk_d;
   reg        tick_d;
   reg        link_en;
   reg [2:0]  state;
   reg [2:0]  bit_cnt;
   reg [4:0]  addr;
   reg [7:0]  cmd;
   reg [6:0]  cmd_shift;
   reg [6:0]  in_shift;
   reg [7:0]  clk_reg [0:`CLK_REGS-1];
   reg [7:0]  shadow [0:`CLK_REGS-1];
   reg [7:0]  ram_mem [0:`RAM_BYTES-1];
   reg [7:0]  trickle;
   reg [7:0]  rd_byte;
   reg        aw_hold;
   reg        w_hold;
   reg [3:0]  aw_addr;
   reg [31:0] w_data;
   reg        w_strb0;
   integer    i;

   bit_sync #(
      .WIDTH (4)
   ) u_pin_sync (
      .clk_i    (mclk_i),
      .arst_n_i (arst_n_i),
      .en_i     (clk_en_i),
      .d_i      ({osc_tick_i, sdio_i, sclk_i, xfer_en_i}),
      .q_o      (pin_s)
   );

   wire       xfer_s  = pin_s[0] & link_en;
   wire       sclk_s  = pin_s[1];
   wire       io_s    = pin_s[2];
   wire       tick_s  = pin_s[3];
   wire       rise    = sclk_s & ~sclk_d;
   wire       fall    = ~sclk_s & sclk_d;
   wire       tick    = tick_s & ~tick_d;

   // Command decode
   wire [7:0] next_cmd   = {io_s, cmd_shift};
   wire       cmd_done   = xfer_s & rise & (state == `ST_CMD) & (bit_cnt == `BIT_LAST);
   wire       nc_burst   = (next_cmd[`CMD_ADDR_HI:`CMD_ADDR_LO] == `BURST_ADDR);
   wire       snap       = cmd_done & nc_burst & next_cmd[`CMD_READ_BIT] & ~next_cmd[`CMD_RAM_BIT];
   wire       is_burst   = (cmd[`CMD_ADDR_HI:`CMD_ADDR_LO] == `BURST_ADDR);
   wire       is_ram     = cmd[`CMD_RAM_BIT];
   wire       is_read    = cmd[`CMD_READ_BIT];
   wire       wp         = clk_reg[`CTRL_IDX][`WP_BIT];
   wire [4:0] burst_last = is_ram ? `RAM_LAST : `CLK_LAST;
   wire [7:0] wbyte      = {io_s, in_shift};
   wire       byte_done  = xfer_s & rise & (state == `ST_DATA) & ~is_read & (bit_cnt == `BIT_LAST);
   wire       wr_ok      = byte_done & cmd[`CMD_WR_EN_BIT];
   wire       clk_single = wr_ok & ~is_ram & ~is_burst & (addr <= `CLK_LAST);
   wire       clk_burst  = wr_ok & ~is_ram & is_burst & ~wp & (addr == `CLK_LAST);
   wire       trk_write  = wr_ok & ~is_ram & ~is_burst & (addr == `TRICKLE_ADDR) & ~wp;
   wire       ram_write  = wr_ok & is_ram & ~wp & (addr <= `RAM_LAST);

   // Byte offered to the link
   always @* begin
      rd_byte = 8'h00;
      if (is_ram) begin
         if (addr <= `RAM_LAST)
            rd_byte = ram_mem[addr];
      end else if (is_burst) begin
         rd_byte = shadow[addr[2:0]];
      end else if (addr <= `CLK_LAST) begin
         rd_byte = clk_reg[addr[2:0]];
      end else if (addr == `TRICKLE_ADDR) begin
         rd_byte = trickle;
      end
   end

   // Link engine
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sclk_d    <= 1'b0;
         tick_d    <= 1'b0;
         state     <= `ST_CMD;
         bit_cnt   <= 3'h0;
         addr      <= 5'h00;
         cmd       <= 8'h00;
         cmd_shift <= 7'h00;
         in_shift  <= 7'h00;
         sdio_o    <= 1'b0;
         sdio_oe_o <= 1'b0;
      end else if (clk_en_i) begin
         sclk_d <= sclk_s;
         tick_d <= tick_s;
         if (!xfer_s) begin
            state     <= `ST_CMD;
            bit_cnt   <= 3'h0;
            addr      <= 5'h00;
            sdio_oe_o <= 1'b0;
         end else begin
            case (state)
               `ST_CMD: begin
                  if (rise) begin
                     cmd_shift[bit_cnt] <= io_s;
                     bit_cnt            <= bit_cnt + 3'h1;
                     if (bit_cnt == `BIT_LAST) begin
                        cmd   <= next_cmd;
                        state <= `ST_DATA;
                        addr  <= nc_burst ? 5'h00 : next_cmd[`CMD_ADDR_HI:`CMD_ADDR_LO];
                     end
                  end
               end
               `ST_DATA: begin
                  if (is_read) begin
                     if (rise)
                        sdio_oe_o <= 1'b0;
                     if (fall) begin
                        sdio_o    <= rd_byte[bit_cnt];
                        sdio_oe_o <= 1'b1;
                        bit_cnt   <= bit_cnt + 3'h1;
                        if (bit_cnt == `BIT_LAST && is_burst)
                           addr <= (addr == burst_last) ? 5'h00 : addr + 5'h01;
                     end
                  end else if (rise) begin
                     in_shift[bit_cnt] <= io_s;
                     bit_cnt           <= bit_cnt + 3'h1;
                     if (bit_cnt == `BIT_LAST) begin
                        if (!is_burst || addr == burst_last)
                           state <= `ST_DONE;
                        else
                           addr <= addr + 5'h01;
                     end
                  end
               end
               `ST_DONE: begin
                  sdio_oe_o <= 1'b0;
               end
               default: begin
                  state <= `ST_CMD;
               end
            endcase
         end
      end
   end

   // Seconds and minutes, BCD, with the halt flag
   wire       halt    = clk_reg[`SEC_IDX][`HALT_BIT];
   wire [7:0] sec     = clk_reg[`SEC_IDX];
   wire [7:0] mins    = clk_reg[`MIN_IDX];
   wire       sec_top = (sec[6:0] >= `BCD_59);
   wire [6:0] sec_nx  = sec_top ? 7'h00 : (sec[3:0] == `BCD_UNIT_9) ?
                        {sec[6:4] + 3'h1, 4'h0} : {sec[6:4], sec[3:0] + 4'h1};
   wire [6:0] min_nx  = (mins[6:0] >= `BCD_59) ? 7'h00 : (mins[3:0] == `BCD_UNIT_9) ?
                        {mins[6:4] + 3'h1, 4'h0} : {mins[6:4], mins[3:0] + 4'h1};

   // Clock registers, shadow set and trickle register
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (i = 0; i < `CLK_REGS; i = i + 1) begin
            clk_reg[i] <= `CLK_RESET;
            shadow[i]  <= `CLK_RESET;
         end
         clk_reg[`CTRL_IDX] <= `CTRL_RESET;
         trickle            <= `TRICKLE_RESET;
      end else if (clk_en_i) begin
         if (tick && !halt) begin
            clk_reg[`SEC_IDX] <= {1'b0, sec_nx};
            if (sec_top)
               clk_reg[`MIN_IDX] <= {mins[7], min_nx};
         end
         if (snap) begin
            for (i = 0; i < `CLK_REGS; i = i + 1)
               shadow[i] <= clk_reg[i];
         end
         if (byte_done && !is_ram && is_burst)
            shadow[addr[2:0]] <= wbyte;
         if (clk_burst) begin
            for (i = 0; i < `CLK_REGS - 1; i = i + 1)
               clk_reg[i] <= shadow[i];
            clk_reg[`CTRL_IDX] <= wbyte & `CTRL_MASK;
         end
         if (clk_single && addr == `CLK_LAST)
            clk_reg[`CTRL_IDX] <= wbyte & `CTRL_MASK;
         else if (clk_single && !wp)
            clk_reg[addr[2:0]] <= wbyte;
         if (trk_write)
            trickle <= wbyte;
      end
   end

   // RAM array, no reset
   always @(posedge mclk_i) begin
      if (clk_en_i && ram_write)
         ram_mem[addr] <= wbyte;
   end

   // Charger decode
   wire [1:0] ds = trickle[`DS_HI:`DS_LO];
   wire [1:0] rs = trickle[`RS_HI:`RS_LO];
   assign charge_on_o = (trickle[`TCS_HI:`TCS_LO] == `TCS_ENABLE) &
                        ((ds == `DS_ONE) | (ds == `DS_TWO)) & (rs != `RS_NONE);
   assign charge_diode_o    = charge_on_o ? ds : 2'b00;
   assign charge_resistor_o = !charge_on_o   ? 3'b000 :
                              (rs == `RS_R1) ? 3'b001 :
                              (rs == `RS_R2) ? 3'b010 : 3'b100;

   // AXI4-Lite slave
   assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_hold & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   wire   aw_hs = s_axi_awvalid & s_axi_awready;
   wire   w_hs  = s_axi_wvalid & s_axi_wready;
   wire   have_aw = aw_hold | aw_hs;
   wire   have_w  = w_hold | w_hs;
   wire [3:0]  wr_addr = aw_hold ? aw_addr : s_axi_awaddr;
   wire [31:0] wr_data = w_hold ? w_data : s_axi_wdata;
   wire        wr_strb = w_hold ? w_strb0 : s_axi_wstrb[0];

   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         aw_hold      <= 1'b0;
         w_hold       <= 1'b0;
         aw_addr      <= 4'h0;
         w_data       <= 32'h0000_0000;
         w_strb0      <= 1'b0;
         link_en      <= `LINK_CTRL_RESET;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= `RESP_OKAY;
         s_axi_rdata  <= 32'h0000_0000;
      end else if (clk_en_i) begin
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (have_aw && have_w && !s_axi_bvalid) begin
            aw_hold      <= 1'b0;
            w_hold       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_addr == `REG_LINK_CTRL || wr_addr == `REG_LINK_STATUS ||
                             wr_addr == `REG_CHARGE || wr_addr == `REG_TIME) ? `RESP_OKAY : `RESP_SLVERR;
            if (wr_addr == `REG_LINK_CTRL && wr_strb)
               link_en <= wr_data[0];
         end else begin
            if (aw_hs) begin
               aw_hold <= 1'b1;
               aw_addr <= s_axi_awaddr;
            end
            if (w_hs) begin
               w_hold <= 1'b1;
               w_data  <= s_axi_wdata;
               w_strb0 <= s_axi_wstrb[0];
            end
         end
         if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
         if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `RESP_OKAY;
            case (s_axi_araddr)
               `REG_LINK_CTRL:   s_axi_rdata <= {31'h0, link_en};
               `REG_LINK_STATUS: s_axi_rdata <= {16'h0, cmd, 5'h0, is_read & ~state[0], is_burst, ~state[0]};
               `REG_CHARGE:      s_axi_rdata <= {16'h0, trickle, 2'b00, charge_resistor_o,
                                                 charge_diode_o, charge_on_o};
               `REG_TIME:        s_axi_rdata <= {16'h0, clk_reg[`MIN_IDX], clk_reg[`SEC_IDX]};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= `RESP_SLVERR;
               end
            endcase
         end
      end
   end

endmodule

// File: verification/timekeeper_burst_access_asserts.sv
/* Checker on the timekeeper ports: charger decode, data-line release, AXI4-Lite answers.
   Assumes clk_en_i stays high; bound onto every timekeeper_burst_access. */
`timescale 1ns/1ps
module timekeeper_burst_access_asserts (
   input wire        mclk_i,
   input wire        arst_n_i,
   input wire        xfer_en_i,
   input wire        sclk_i,
   input wire        sdio_oe_o,
   input wire        charge_on_o,
   input wire [1:0]  charge_diode_o,
   input wire [2:0]  charge_resistor_o,
   input wire [3:0]  s_axi_araddr,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire        s_axi_awready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!arst_n_i);
   a_res_one_hot: assert property ($onehot0(charge_resistor_o))
      else $error("resistor select not one-hot");
   a_on_needs_path: assert property (
      charge_on_o |-> charge_resistor_o != 3'b000 && (charge_diode_o == 2'b01 || charge_diode_o == 2'b10))
      else $error("charger on without diode and resistor");
   a_off_all_zero: assert property (!charge_on_o |-> charge_diode_o == 2'b00 && charge_resistor_o == 3'b000)
      else $error("charger path selected while off");
   a_en_low_release: assert property (!xfer_en_i [*5] |-> !sdio_oe_o)
      else $error("data line driven with enable low");
   a_sclk_hi_release: assert property (sclk_i [*4] |-> !sdio_oe_o)
      else $error("data line driven through high serial clock");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped early");
   a_read_slverr: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'b00
      |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
      else $error("unaligned read not refused");
   a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped early");
   a_no_aw_in_b: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write address taken during response");
endmodule
bind timekeeper_burst_access timekeeper_burst_access_asserts chk (.mclk_i, .arst_n_i, .xfer_en_i, .sclk_i,
   .sdio_oe_o, .charge_on_o, .charge_diode_o, .charge_resistor_o, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_awready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready);

// File: verification/link_host.sv
/* Host model on the three-wire timekeeper link: enable, serial clock, pulled-down data line.
   Assumes mclk_i at 50 MHz; one link clock period is 8 mclk cycles (160 ns). */
`timescale 1ns/1ps
module link_host (
   input  wire mclk_i,
   input  wire dev_d_i,
   input  wire dev_oe_i,
   output reg  xfer_en_o,
   output reg  sclk_o,
   output wire line_o
);
   reg drv;
   reg d;
   // Pull-down holds the line low when released
   assign line_o = dev_oe_i ? dev_d_i : (drv & d);
   initial begin
      xfer_en_o = 1'b0;
      sclk_o = 1'b0;
      drv = 1'b0;
      d = 1'b0;
   end
   task wt(input integer n);
      repeat (n) @(posedge mclk_i);
   endtask
   task start;
      begin
         wt(4);
         xfer_en_o <= 1'b1;
         wt(4);
      end
   endtask
   task stop;
      begin
         sclk_o <= 1'b0;
         drv <= 1'b0;
         wt(4);
         xfer_en_o <= 1'b0;
         wt(8);
      end
   endtask
   // One byte, LSB first; wr drives the line, otherwise it is sampled after the rise
   task io(input [7:0] o, input wr, output [7:0] in);
      integer i;
      begin
         for (i = 0; i < 8; i = i + 1) begin
            sclk_o <= 1'b0;
            drv <= wr;
            d <= o[i];
            wt(4);
            sclk_o <= 1'b1;
            wt(1);
            in[i] = line_o;
            wt(3);
         end
      end
   endtask
endmodule

// File: verification/tb_top.sv
/* Self-checking bench of the timekeeper: AXI4-Lite map, charger decode, RAM and clock bursts.
   Assumes link_host as the link partner and the bound port checker. */
`timescale 1ns/1ps
module tb_top;
   reg         mclk_i;
   reg         arst_n_i;
   reg         osc_tick_i;
   reg  [3:0]  s_axi_awaddr;
   reg         s_axi_awvalid;
   reg  [31:0] s_axi_wdata;
   reg         s_axi_wvalid;
   reg         s_axi_bready;
   reg  [3:0]  s_axi_araddr;
   reg         s_axi_arvalid;
   reg         s_axi_rready;
   wire        xfer_en;
   wire        sclk;
   wire        line;
   wire        sdio_o;
   wire        sdio_oe_o;
   wire        charge_on_o;
   wire [1:0]  charge_diode_o;
   wire [2:0]  charge_resistor_o;
   wire        s_axi_awready;
   wire        s_axi_wready;
   wire [1:0]  s_axi_bresp;
   wire        s_axi_bvalid;
   wire        s_axi_arready;
   wire [31:0] s_axi_rdata;
   wire [1:0]  s_axi_rresp;
   wire        s_axi_rvalid;
   integer     errors;
   integer     checks;
   integer     seed;
   integer     i;
   reg  [31:0] v;
   reg  [1:0]  r;
   reg  [7:0]  b;
   reg  [7:0]  tc;
   reg  [7:0]  ram [0:30];
   timekeeper_burst_access uut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .clk_en_i(1'b1), .xfer_en_i(xfer_en),
      .sclk_i(sclk), .sdio_i(line), .sdio_o(sdio_o), .sdio_oe_o(sdio_oe_o), .osc_tick_i(osc_tick_i),
      .charge_on_o(charge_on_o), .charge_diode_o(charge_diode_o), .charge_resistor_o(charge_resistor_o),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready));
   link_host h (.mclk_i(mclk_i), .dev_d_i(sdio_o), .dev_oe_i(sdio_oe_o), .xfer_en_o(xfer_en), .sclk_o(sclk),
      .line_o(line));
   always #10 mclk_i = ~mclk_i;
   function [5:0] chg(input [7:0] t);
      reg on;
      begin
         on = t[7:4] == 4'ha && (t[3:2] == 2'b01 || t[3:2] == 2'b10) && t[1:0] != 2'b00;
         chg = on ? {3'b001 << (t[1:0] - 2'b01), t[3:2], 1'b1} : 6'h00;
      end
   endfunction
   task tally_and_finish;
      begin
         $display("checks %0d errors %0d", checks, errors);
         if (errors == 0 && checks > 0) $display("No errors found");
         else $display("Errors were found");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task axi_wr(input [3:0] a, input [31:0] d, output [1:0] rs);
      integer n;
      reg ok;
      begin
         ok = 1'b0;
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         for (n = 0; n < 40 && !ok; n = n + 1) begin
            @(posedge mclk_i);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
               rs = s_axi_bresp;
               ok = 1'b1;
               s_axi_bready <= 1'b0;
            end
         end
         if (!ok) chk(32'h0, 32'h1);
         if (!ok) tally_and_finish;
         @(posedge mclk_i);
      end
   endtask
   task axi_rd(input [3:0] a, output [31:0] d, output [1:0] rs);
      integer n;
      reg ok;
      begin
         ok = 1'b0;
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         for (n = 0; n < 40 && !ok; n = n + 1) begin
            @(posedge mclk_i);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
               d = s_axi_rdata;
               rs = s_axi_rresp;
               ok = 1'b1;
               s_axi_rready <= 1'b0;
            end
         end
         if (!ok) chk(32'h0, 32'h1);
         if (!ok) tally_and_finish;
         @(posedge mclk_i);
      end
   endtask
   task wr1(input [7:0] c, input [7:0] d);
      begin
         h.start;
         h.io(c, 1'b1, b);
         h.io(d, 1'b1, b);
         h.stop;
      end
   endtask
   task rd1(input [7:0] c, output [7:0] o);
      begin
         h.start;
         h.io(c, 1'b1, o);
         h.io(8'h00, 1'b0, o);
         h.stop;
      end
   endtask
   task tick;
      begin
         repeat (4) @(posedge mclk_i);
         osc_tick_i <= 1'b1;
         repeat (4) @(posedge mclk_i);
         osc_tick_i <= 1'b0;
         repeat (4) @(posedge mclk_i);
      end
   endtask
   initial begin
      mclk_i = 1'b0;
      arst_n_i = 1'b0;
      osc_tick_i = 1'b0;
      s_axi_awaddr = 4'h0;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 4'h0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      errors = 0;
      checks = 0;
      seed = 32'h4347d69e;
      repeat (8) @(posedge mclk_i);
      arst_n_i <= 1'b1;
      repeat (6) @(posedge mclk_i);
      axi_rd(4'h0, v, r);
      chk(v, 32'h1);
      axi_rd(4'h8, v, r);
      chk(v, 32'h0);
      axi_rd(4'h2, v, r);
      chk(r, 32'h2);
      axi_wr(4'h6, 32'h0, r);
      chk(r, 32'h2);
      $display("test reset_map done");
      for (i = 0; i < 12; i = i + 1) begin
         tc = (i < 8) ? {4'ha, i[2] ? 2'b10 : 2'b01, i[1:0]} : $random(seed);
         if (i == 8) tc = 8'hae;
         wr1(8'h90, tc);
         rd1(8'h91, b);
         chk(b, tc);
         axi_rd(4'h8, v, r);
         chk(v, {16'h0, tc, 2'b00, chg(tc)});
         chk({charge_resistor_o, charge_diode_o, charge_on_o}, chg(tc));
      end
      $display("test charger done");
      h.start;
      h.io(8'hfe, 1'b1, b);
      for (i = 0; i < 31; i = i + 1) begin
         ram[i] = (i == 0) ? 8'hff : (i == 30) ? 8'h00 : $random(seed);
         h.io(ram[i], 1'b1, b);
      end
      h.stop;
      h.start;
      h.io(8'hff, 1'b1, b);
      for (i = 0; i < 32; i = i + 1) begin
         h.io(8'h00, 1'b0, b);
         chk(b, ram[i % 31]);
      end
      h.stop;
      rd1(8'hfd, b);
      chk(b, ram[30]);
      wr1(8'h40, 8'h5a);
      rd1(8'hc1, b);
      chk(b, ram[0]);
      $display("test ram done");
      wr1(8'h90, 8'ha5);
      h.start;
      h.io(8'hbe, 1'b1, b);
      for (i = 0; i < 8; i = i + 1) h.io((i == 0) ? 8'h59 : (i == 1) ? 8'h12 : (i == 7) ? 8'h00 : 8'h01, 1'b1, b);
      h.stop;
      axi_rd(4'hc, v, r);
      chk(v, 32'h1259);
      h.start;
      h.io(8'hbf, 1'b1, b);
      tick;
      axi_rd(4'h4, v, r);
      chk(v, 32'h0000_bf07);
      for (i = 0; i < 9; i = i + 1) begin
         h.io(8'h00, 1'b0, b);
         if (i == 0 || i == 8) chk(b, 8'h59);
         if (i == 1) chk(b, 8'h12);
         if (i == 7) chk(b, 8'h00);
      end
      h.stop;
      axi_rd(4'hc, v, r);
      chk(v, 32'h1300);
      $display("test clock_burst done");
      wr1(8'h8e, 8'h80);
      h.start;
      h.io(8'hbe, 1'b1, b);
      for (i = 0; i < 8; i = i + 1) h.io(8'h33, 1'b1, b);
      h.stop;
      axi_rd(4'hc, v, r);
      chk(v, 32'h1300);
      rd1(8'h8f, b);
      chk(b, 8'h80);
      wr1(8'h8e, 8'h00);
      axi_wr(4'h0, 32'h0, r);
      rd1(8'hc1, b);
      chk(b, 8'h00);
      axi_wr(4'h0, 32'h1, r);
      rd1(8'hc1, b);
      chk(b, ram[0]);
      $display("test protect_link done");
      tally_and_finish;
   end
endmodule
